//--- logic/twisl_top.sv
/*
 * twisl_top: two-wire interface with software master (bit-banged lines)
 * and a hardware slave answering four addresses with clock stretching.
 * Assumes a single-cycle register port from the core and open-drain
 * pads resolved outside from the output enables.
 */
// How it works
// (R1) data access loads/returns byte, clears flag
// (R2) second data access per interrupt halts controller
// (R3) fourth address register, writable, resets zero
// (R4) slave answers any of four addresses
// (R5) spikes under fifty nanoseconds are filtered
// (R6) master-select bit enables software master mode
// (R7) data pin follows drive value when enabled
// (R8) master mode clock pin always driven
// (R9) sample bit latches data on clock rise
// (R10) software sequences start, bytes, acks, stop
// (R11) slave default; active only both selects clear
// (R12) flag set after start, address, direction
// (R13) interrupt needs own and global enable
// (R14) interrupt request after each acked byte
// (R15) first byte shows address plus direction
// (R16) direction bit mirrors master read/write bit
// (R17) clock held low until flag cleared
// (R18) flag per acked byte; nack none
// (R19) stop or nack returns slave to idle
// (R20) interface reset bit forces idle
// (R21) two-bit source code for each interrupt
// (R22) address compared to all four registers
`timescale 1ns/10ps
`default_nettype none

module twisl_top
    import twisl_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       clkEn,
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrEn,
    input  wire logic       sfrRdEn,
    input  wire logic [7:0] sfrWdata,
    output var  logic [7:0] sfrRdata,
    input  wire logic       serialPeriphSelect,
    input  wire logic       twiIrqEnable,
    input  wire logic       globalIrqEnable,
    output var  logic       irqReq,
    input  wire logic       serialDataPinIn,
    output var  logic       serialDataPinOut,
    output var  logic       serialDataPinOe,
    input  wire logic       serialClockPinIn,
    output var  logic       serialClockPinOut,
    output var  logic       serialClockPinOe
);
    import twisl_pkg::*;

    logic [7:0]   slaveAddressOne_q;
    logic [7:0]   slaveAddressTwo_q;
    logic [7:0]   slaveAddressThree_q;
    logic [7:0]   slaveAddressFour_q;
    logic [7:0]   serialByteBuffer_q;
    logic         dataDriveValue_q;
    logic         dataDriveEnable_q;
    logic         clockDriveValue_q;
    logic         dataSampleBit_q;
    logic         masterSelect_q;
    logic         interfaceReset_q;
    logic         transferDirection_q;
    logic         twiIrqFlag_q;
    logic [1:0]   irqSource_q;
    logic         serviced_q;
    twisl_state_t state_q;
    logic [7:0]   shift_q;
    logic [3:0]   bitCnt_q;
    logic         ackBit_q;
    logic         restart_q;
    logic         sdaClean;
    logic         sclClean;
    logic         sdaPrev_q;
    logic         sclPrev_q;
    logic         sclRise;
    logic         sclFall;
    logic         startSeen;
    logic         stopSeen;
    logic         slaveOn;
    logic         dataAccess;
    logic         haltNow;
    logic         addrMatch;
    logic         flagSet;
    logic [1:0]   flagSrc;

    twisl_glitch_filter #(.STABLE_CYC(SPIKE_CYCLES)) u_sda_filter ( // R5
        .mclk     (mclk),
        .reset    (reset),
        .clkEn    (clkEn),
        .pinRaw   (serialDataPinIn),
        .pinClean (sdaClean)
    );

    twisl_glitch_filter #(.STABLE_CYC(SPIKE_CYCLES)) u_scl_filter ( // R5
        .mclk     (mclk),
        .reset    (reset),
        .clkEn    (clkEn),
        .pinRaw   (serialClockPinIn),
        .pinClean (sclClean)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            sdaPrev_q <= 1'b1;
            sclPrev_q <= 1'b1;
        end else if (clkEn) begin
            sdaPrev_q <= sdaClean;
            sclPrev_q <= sclClean;
        end
    end

    assign sclRise    = sclClean & ~sclPrev_q;
    assign sclFall    = ~sclClean & sclPrev_q;
    assign startSeen  = sclClean & sclPrev_q & sdaPrev_q & ~sdaClean;
    assign stopSeen   = sclClean & sclPrev_q & ~sdaPrev_q & sdaClean;
    assign slaveOn    = ~serialPeriphSelect & ~masterSelect_q; // R11
    assign dataAccess = clkEn & (sfrWrEn | sfrRdEn) & (sfrAddr == OFS_SERIAL_BYTE_BUFFER);
    // a second data access after the flag is already gone
    assign haltNow    = dataAccess & ~twiIrqFlag_q & serviced_q & slaveOn; // R2
    assign addrMatch  = (shift_q[7:1] == slaveAddressOne_q[6:0])   // R22
                      | (shift_q[7:1] == slaveAddressTwo_q[6:0])   // R4
                      | (shift_q[7:1] == slaveAddressThree_q[6:0])
                      | (shift_q[7:1] == slaveAddressFour_q[6:0]);

    // register writes
    always_ff @(posedge mclk) begin
        if (reset) begin
            slaveAddressOne_q   <= RST_SLAVE_ADDRESS_ONE;
            slaveAddressTwo_q   <= RST_SLAVE_ADDRESS_OTHER;
            slaveAddressThree_q <= RST_SLAVE_ADDRESS_OTHER;
            slaveAddressFour_q  <= RST_SLAVE_ADDRESS_OTHER;   // R3
            dataDriveValue_q    <= 1'b0;
            dataDriveEnable_q   <= 1'b0;
            clockDriveValue_q   <= 1'b1;
            masterSelect_q      <= 1'b0;                      // R11
            interfaceReset_q    <= 1'b0;
        end else if (clkEn && sfrWrEn) begin
            case (sfrAddr)
                OFS_SLAVE_ADDRESS_ONE:   slaveAddressOne_q   <= sfrWdata;
                OFS_SLAVE_ADDRESS_TWO:   slaveAddressTwo_q   <= sfrWdata;
                OFS_SLAVE_ADDRESS_THREE: slaveAddressThree_q <= sfrWdata;
                OFS_SLAVE_ADDRESS_FOUR:  slaveAddressFour_q  <= sfrWdata; // R3
                OFS_TWI_CONTROL_REG: begin
                    dataDriveValue_q  <= sfrWdata[BIT_DATA_DRIVE_VALUE];
                    dataDriveEnable_q <= sfrWdata[BIT_DATA_DRIVE_ENABLE];
                    clockDriveValue_q <= sfrWdata[BIT_CLOCK_DRIVE_VALUE];
                    masterSelect_q    <= sfrWdata[BIT_MASTER_SELECT];     // R6
                    interfaceReset_q  <= sfrWdata[BIT_INTERFACE_RESET];   // R20
                end
                default: ;
            endcase
        end
    end

    // sample bit only tracks the pin while software is receiving
    always_ff @(posedge mclk) begin
        if (reset) begin
            dataSampleBit_q <= 1'b0;
        end else if (clkEn && !dataDriveEnable_q && sclRise) begin
            dataSampleBit_q <= sdaClean; // R9
        end
    end

    // register reads, answered one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            sfrRdata <= 8'h00;
        end else if (clkEn && sfrRdEn) begin
            case (sfrAddr)
                OFS_SLAVE_ADDRESS_ONE:   sfrRdata <= slaveAddressOne_q;
                OFS_SLAVE_ADDRESS_TWO:   sfrRdata <= slaveAddressTwo_q;
                OFS_SLAVE_ADDRESS_THREE: sfrRdata <= slaveAddressThree_q;
                OFS_SLAVE_ADDRESS_FOUR:  sfrRdata <= slaveAddressFour_q;
                OFS_SERIAL_BYTE_BUFFER:  sfrRdata <= serialByteBuffer_q; // R1
                OFS_TWI_CONTROL_REG: begin
                    // bits 5:4 are shared: master lines or slave source code
                    sfrRdata <= {dataDriveValue_q, dataDriveEnable_q,
                                 masterSelect_q ? {clockDriveValue_q, dataSampleBit_q} : irqSource_q, // R21
                                 masterSelect_q, interfaceReset_q, transferDirection_q, twiIrqFlag_q};
                end
                default: sfrRdata <= 8'h00;
            endcase
        end
    end

    // slave sequencer
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q             <= S_IDLE;
            shift_q             <= 8'h00;
            bitCnt_q            <= 4'h0;
            ackBit_q            <= 1'b1;
            restart_q           <= 1'b0;
            transferDirection_q <= 1'b0;
            flagSet             <= 1'b0;
            flagSrc             <= SRC_START_MATCH;
        end else if (clkEn) begin
            flagSet <= 1'b0;
            if (!slaveOn || interfaceReset_q) begin
                state_q <= S_IDLE; // R20
            end else if (state_q == S_HALT) begin
                state_q <= S_HALT;
            end else if (haltNow) begin
                state_q <= S_HALT; // R2
            end else if (stopSeen && state_q != S_IDLE) begin
                if (state_q != S_ADDR) begin
                    flagSet <= 1'b1;
                    flagSrc <= SRC_STOP; // R21
                end
                state_q <= S_IDLE; // R19
            end else if (startSeen) begin
                restart_q <= (state_q != S_IDLE); // R12
                bitCnt_q  <= 4'h0;
                state_q   <= S_ADDR;
            end else begin
                case (state_q)
                    S_IDLE: ;
                    S_ADDR, S_RX: begin
                        if (sclRise) begin
                            shift_q  <= {shift_q[6:0], sdaClean};
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end else if (sclFall && bitCnt_q == BITS_PER_BYTE) begin
                            if (state_q == S_RX) begin
                                state_q <= S_RX_ACK;
                            end else if (addrMatch) begin
                                transferDirection_q <= shift_q[0]; // R16
                                state_q             <= S_ADDR_ACK;
                            end else begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_ADDR_ACK, S_RX_ACK: begin
                        if (sclFall) begin
                            flagSet <= 1'b1; // R12
                            flagSrc <= (state_q == S_RX_ACK) ? SRC_USER_DATA
                                     : (restart_q ? SRC_RESTART_MATCH : SRC_START_MATCH); // R21
                            state_q <= S_WAIT;
                        end
                    end
                    S_WAIT: begin
                        if (!twiIrqFlag_q && !flagSet) begin
                            bitCnt_q <= 4'h0;
                            shift_q  <= serialByteBuffer_q;
                            state_q  <= transferDirection_q ? S_TX : S_RX; // R16
                        end
                    end
                    S_TX: begin
                        if (sclFall) begin
                            shift_q  <= {shift_q[6:0], 1'b1};
                            bitCnt_q <= bitCnt_q + 4'h1;
                            if (bitCnt_q == BITS_PER_BYTE - 4'h1) begin
                                state_q <= S_TX_ACK;
                            end
                        end
                    end
                    S_TX_ACK: begin
                        if (sclRise) begin
                            ackBit_q <= sdaClean;
                        end else if (sclFall) begin
                            if (!ackBit_q) begin
                                flagSet <= 1'b1; // R18
                                flagSrc <= SRC_USER_DATA;
                                state_q <= S_WAIT;
                            end else begin
                                state_q <= S_IDLE; // R19
                            end
                        end
                    end
                    default: state_q <= S_IDLE;
                endcase
            end
        end
    end

    // byte buffer: software write, received byte, or address byte
    always_ff @(posedge mclk) begin
        if (reset) begin
            serialByteBuffer_q <= RST_SERIAL_BYTE_BUFFER;
        end else if (clkEn) begin
            if (sfrWrEn && sfrAddr == OFS_SERIAL_BYTE_BUFFER) begin
                serialByteBuffer_q <= sfrWdata; // R1
            end else if (sclFall && bitCnt_q == BITS_PER_BYTE && slaveOn && !interfaceReset_q
                         && (state_q == S_RX || (state_q == S_ADDR && addrMatch))
                         && !startSeen && !stopSeen && !haltNow) begin
                serialByteBuffer_q <= shift_q; // R15
            end
        end
    end

    // interrupt flag: a new event wins over a clearing access
    always_ff @(posedge mclk) begin
        if (reset) begin
            twiIrqFlag_q <= 1'b0;
            irqSource_q  <= SRC_START_MATCH;
            serviced_q   <= 1'b0;
        end else if (clkEn) begin
            if (!slaveOn || interfaceReset_q) begin
                twiIrqFlag_q <= 1'b0;
                serviced_q   <= 1'b0;
            end else if (flagSet) begin
                twiIrqFlag_q <= 1'b1; // R18
                irqSource_q  <= flagSrc;
                serviced_q   <= 1'b0;
            end else if (dataAccess) begin
                twiIrqFlag_q <= 1'b0; // R1
                serviced_q   <= 1'b1;
            end
        end
    end

    // request stays up until the flag or an enable drops; vectoring is the core's job
    always_ff @(posedge mclk) begin
        if (reset) begin
            irqReq <= 1'b0;
        end else if (clkEn) begin
            irqReq <= twiIrqFlag_q & twiIrqEnable & globalIrqEnable; // R13 R14
        end
    end

    // pad drivers; slave only ever pulls low
    always_ff @(posedge mclk) begin
        if (reset) begin
            serialDataPinOut  <= 1'b1;
            serialDataPinOe   <= 1'b0;
            serialClockPinOut <= 1'b1;
            serialClockPinOe  <= 1'b0;
        end else if (clkEn) begin
            if (masterSelect_q && !serialPeriphSelect) begin
                serialClockPinOe  <= 1'b1;                 // R8
                serialClockPinOut <= clockDriveValue_q;    // R8
                serialDataPinOe   <= dataDriveEnable_q;    // R7
                serialDataPinOut  <= dataDriveValue_q;     // R7
            end else begin
                serialClockPinOut <= 1'b0;
                serialDataPinOut  <= 1'b0;
                serialClockPinOe  <= slaveOn && !interfaceReset_q && state_q == S_WAIT; // R17
                serialDataPinOe   <= slaveOn && !interfaceReset_q
                                   && (state_q == S_ADDR_ACK || state_q == S_RX_ACK
                                       || (state_q == S_TX && !shift_q[7]));
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    chk_flag_clear: assert property (dataAccess && twiIrqFlag_q && !flagSet && slaveOn && !interfaceReset_q
        |=> !twiIrqFlag_q) else $error("flag not cleared by data access"); // R1
    chk_halt_entry: assert property (haltNow && !interfaceReset_q |=> state_q == S_HALT)
        else $error("double access did not halt"); // R2
    chk_addr_four: assert property (clkEn && sfrWrEn && sfrAddr == OFS_SLAVE_ADDRESS_FOUR
        |=> slaveAddressFour_q == $past(sfrWdata)) else $error("fourth address not written"); // R3
    chk_irq_gate: assert property (clkEn |=> irqReq == $past(twiIrqFlag_q && twiIrqEnable && globalIrqEnable))
        else $error("interrupt request gating wrong"); // R13
    chk_master_clock: assert property (clkEn && masterSelect_q && !serialPeriphSelect
        |=> serialClockPinOe && serialClockPinOut == $past(clockDriveValue_q)) else $error("master clock pin wrong"); // R8
    chk_master_data: assert property (clkEn && masterSelect_q && !serialPeriphSelect
        |=> serialDataPinOe == $past(dataDriveEnable_q) && serialDataPinOut == $past(dataDriveValue_q))
        else $error("master data pin wrong"); // R7
    chk_clock_stretch: assert property (clkEn && slaveOn && !interfaceReset_q && state_q == S_WAIT
        |=> serialClockPinOe && !serialClockPinOut) else $error("clock not held low while waiting"); // R17
    chk_reset_idle: assert property (clkEn && interfaceReset_q |=> state_q == S_IDLE)
        else $error("interface reset did not idle"); // R20
    chk_nack_idle: assert property (clkEn && slaveOn && !interfaceReset_q && state_q == S_TX_ACK
        && sclFall && ackBit_q && !startSeen |=> state_q == S_IDLE && !flagSet) else $error("nack did not idle"); // R19
    chk_sample_bit: assert property (clkEn && !dataDriveEnable_q && sclRise |=> dataSampleBit_q == $past(sdaClean))
        else $error("sample bit missed clock rise"); // R9

    cov_addr_match: cover property (state_q == S_ADDR_ACK ##[1:100] state_q == S_WAIT);
    cov_tx_byte: cover property (state_q == S_TX ##[1:200] state_q == S_TX_ACK);
    cov_stop_flag: cover property (flagSet && flagSrc == SRC_STOP);
    cov_halt: cover property (state_q == S_HALT);
endmodule // twisl_top

`default_nettype wire

//--- logic/twisl_pkg.sv
/*
 * twisl_pkg: register offsets, reset values, control field positions,
 * interrupt source codes, filter timing and the slave state type.
 * Assumes a 10 MHz core clock and special-function-register style access.
 */
`default_nettype none

package twisl_pkg;
    // register offsets on the special-function-register port
    localparam logic [7:0] OFS_SLAVE_ADDRESS_ONE   = 8'h9B;
    localparam logic [7:0] OFS_SLAVE_ADDRESS_TWO   = 8'h91;
    localparam logic [7:0] OFS_SLAVE_ADDRESS_THREE = 8'h92;
    localparam logic [7:0] OFS_SLAVE_ADDRESS_FOUR  = 8'h93;
    localparam logic [7:0] OFS_SERIAL_BYTE_BUFFER  = 8'h9A;
    localparam logic [7:0] OFS_TWI_CONTROL_REG     = 8'hE8;

    // values after reset
    localparam logic [7:0] RST_SLAVE_ADDRESS_ONE   = 8'h55;
    localparam logic [7:0] RST_SLAVE_ADDRESS_OTHER = 8'h00;
    localparam logic [7:0] RST_SERIAL_BYTE_BUFFER  = 8'h00;

    // control register bit positions
    localparam int BIT_DATA_DRIVE_VALUE  = 7;
    localparam int BIT_DATA_DRIVE_ENABLE = 6;
    localparam int BIT_CLOCK_DRIVE_VALUE = 5;
    localparam int BIT_DATA_SAMPLE       = 4;
    localparam int BIT_IRQ_SOURCE_HI     = 5;
    localparam int BIT_IRQ_SOURCE_LO     = 4;
    localparam int BIT_MASTER_SELECT     = 3;
    localparam int BIT_INTERFACE_RESET   = 2;
    localparam int BIT_TRANSFER_DIR      = 1;
    localparam int BIT_TWI_IRQ_FLAG      = 0;

    // interrupt source codes
    localparam logic [1:0] SRC_START_MATCH  = 2'h0;
    localparam logic [1:0] SRC_RESTART_MATCH = 2'h1;
    localparam logic [1:0] SRC_USER_DATA    = 2'h2;
    localparam logic [1:0] SRC_STOP         = 2'h3;

    // spike filter timing
    localparam int SPIKE_WIDTH_NS = 50;
    localparam int MCLK_PERIOD_NS = 100;
    localparam int SPIKE_CYC_RAW  = (SPIKE_WIDTH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int SPIKE_CYCLES   = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ADDR_ACK, S_WAIT, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_HALT
    } twisl_state_t;
endpackage

`default_nettype wire

//--- logic/twisl_glitch_filter.sv
/*
 * twisl_glitch_filter: two-flop synchroniser followed by a stability
 * filter; the output follows the pin only after it has held a level for
 * more than STABLE_CYC clocks. Assumes the pin is asynchronous to mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module twisl_glitch_filter #(
    parameter int STABLE_CYC = 1
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic clkEn,
    input  wire logic pinRaw,
    output var  logic pinClean
);
    localparam int CW = $clog2(STABLE_CYC + 2);

    logic          sync1_q;
    logic          sync2_q;
    logic [CW-1:0] stableCnt_q;

    if (STABLE_CYC < 1) begin : g_bad_stable
        $error("twisl_glitch_filter: STABLE_CYC must be at least 1");
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else if (clkEn) begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
        end
    end

    // bus idles high, so the filter starts high
    always_ff @(posedge mclk) begin
        if (reset) begin
            stableCnt_q <= '0;
            pinClean    <= 1'b1;
        end else if (clkEn) begin
            if (sync2_q == pinClean) begin
                stableCnt_q <= '0;
            end else if (stableCnt_q >= CW'(STABLE_CYC)) begin
                pinClean    <= sync2_q;
                stableCnt_q <= '0;
            end else begin
                stableCnt_q <= stableCnt_q + CW'(1);
            end
        end
    end
endmodule // twisl_glitch_filter

`default_nettype wire

//--- bench/twisl_bus_master.sv
/* twisl_bus_master: behavioural external bus master for the slave side.
   Assumes the bench resolves both open-drain wires with pull-ups. */
`timescale 1ns/10ps
`default_nettype none

module twisl_bus_master (
    input  wire logic sclWire,
    input  wire logic sdaWire,
    output var  logic sclDrv,
    output var  logic sdaDrv
);
    initial begin
        sclDrv = 1'b1;
        sdaDrv = 1'b1;
    end

    // long low phase: slave data lags a falling edge by about six mclk
    // bounded, so a stuck stretch cannot hang the run
    task automatic rise();
        int n;
        #400 sclDrv = 1'b1;
        n = 0;
        while (sclWire === 1'b0 && n < 5000) begin
            #100 n++;
        end
    endtask

    task automatic pulse(output logic s);
        rise();
        #100 s = sdaWire;
        #100 sclDrv = 1'b0;
        #200;
    endtask

    task automatic start();
        sdaDrv = 1'b1;
        sclDrv = 1'b1;
        #400 sdaDrv = 1'b0;
        #400 sclDrv = 1'b0;
        #200;
    endtask

    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            sdaDrv = d[i];
            pulse(s);
        end
        sdaDrv = 1'b1;
        pulse(s);
        ack = ~s;
    endtask

    task automatic recvByte(input logic nack, output logic [7:0] d);
        logic s;
        sdaDrv = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            pulse(s);
            d[i] = s;
        end
        sdaDrv = nack;
        pulse(s);
        sdaDrv = 1'b1;
    endtask

    task automatic stop();
        sdaDrv = 1'b0;
        rise();
        #400 sdaDrv = 1'b1;
        #400;
    endtask
endmodule // twisl_bus_master

`default_nettype wire

//--- bench/twisl_top_tb_top.sv
/* twisl_top_tb_top: register-port tests of slave and software master modes.
   Assumes twisl_pkg is compiled first and a 10 MHz mclk. */
`timescale 1ns/10ps
`default_nettype none

module twisl_top_tb_top;
    import twisl_pkg::*;
    logic mclk, reset, wrEn, rdEn, sps, ownIe, glbIe, ack;
    logic [7:0] addr, wdata, rdata, v;
    logic irq, dOut, dOe, cOut, cOe, sdaDrv, sclDrv, sdaW, sclW;
    int errCount = 0;
    int numChecks = 0;

    assign sdaW = ~(dOe & ~dOut) & sdaDrv;
    assign sclW = (cOe ? cOut : 1'b1) & sclDrv;

    twisl_top twisl_top_i (.mclk(mclk), .reset(reset), .clkEn(1'b1), .sfrAddr(addr),
        .sfrWrEn(wrEn), .sfrRdEn(rdEn), .sfrWdata(wdata), .sfrRdata(rdata),
        .serialPeriphSelect(sps), .twiIrqEnable(ownIe), .globalIrqEnable(glbIe),
        .irqReq(irq), .serialDataPinIn(sdaW), .serialDataPinOut(dOut),
        .serialDataPinOe(dOe), .serialClockPinIn(sclW), .serialClockPinOut(cOut),
        .serialClockPinOe(cOe));
    twisl_bus_master twisl_bus_master_i (.sclWire(sclW), .sdaWire(sdaW),
        .sclDrv(sclDrv), .sdaDrv(sdaDrv));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) addr <= a;
        wdata <= d;
        wrEn <= 1'b1;
        @(posedge mclk) wrEn <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) addr <= a;
        rdEn <= 1'b1;
        @(posedge mclk) rdEn <= 1'b0;
        @(negedge mclk) d = rdata;
    endtask

    task automatic waitFlag();
        v = 8'h00;
        for (int i = 0; i < 40 && v[0] !== 1'b1; i++) rd(OFS_TWI_CONTROL_REG, v);
        v = v & 8'h33;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #3_000_000 errCount++;
        results();
    end

    initial begin
        {reset, wrEn, rdEn, sps, addr, wdata} = {1'b1, 19'h0};
        {ownIe, glbIe} = 2'b11;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        repeat (6) @(posedge mclk);
        rd(8'h93, v); chk(v, 8'h00);
        rd(8'h9A, v); chk(v, 8'h00);
        wr(8'h93, 8'h2A);
        rd(8'h93, v); chk(v, 8'h2A);
        $display("test registers done");
        twisl_bus_master_i.start();
        twisl_bus_master_i.sendByte(8'h22, ack); chk(ack, 0);
        twisl_bus_master_i.stop();
        rd(8'hE8, v); chk(v & 8'h01, 8'h00);
        twisl_bus_master_i.start();
        twisl_bus_master_i.sendByte(8'h54, ack); chk(ack, 1);
        waitFlag(); chk(v, 8'h01);
        chk({cOe, cOut}, 8'h02);
        chk(irq, 1);
        glbIe <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(irq, 0);
        glbIe <= 1'b1;
        rd(8'h9A, v); chk(v, 8'h54);
        rd(8'hE8, v); chk(v & 8'h01, 8'h00);
        twisl_bus_master_i.sendByte(8'hC3, ack); chk(ack, 1);
        waitFlag(); chk(v, 8'h21);
        rd(8'h9A, v); chk(v, 8'hC3);
        twisl_bus_master_i.stop();
        waitFlag(); chk(v, 8'h31);
        $display("test slave done");
        wr(8'hE8, 8'h48);
        repeat (2) @(negedge mclk);
        chk({dOe, dOut, cOe, cOut}, 8'h0A);
        wr(8'hE8, 8'hE8);
        repeat (2) @(negedge mclk);
        chk({dOe, dOut, cOe, cOut}, 8'h0F);
        // sample follows the wire only on a clock rise
        for (int b = 0; b < 2; b++) begin
            twisl_bus_master_i.sdaDrv <= b[0];
            wr(8'hE8, 8'h08);
            repeat (8) @(posedge mclk);
            wr(8'hE8, 8'h28);
            repeat (8) @(posedge mclk);
            twisl_bus_master_i.sdaDrv <= ~b[0];
            repeat (8) @(posedge mclk);
            rd(8'hE8, v); chk(v[4], b[0]);
        end
        wr(8'hE8, 8'h00);
        $display("test master done");
        @(negedge mclk);
        twisl_bus_master_i.start();
        twisl_bus_master_i.sendByte(8'h55, ack); chk(ack, 8'h01);
        waitFlag(); chk(v, 8'h03);
        wr(8'h9A, 8'hA4);
        @(negedge mclk);
        twisl_bus_master_i.recvByte(1'b0, v); chk(v, 8'hA4);
        waitFlag(); chk(v, 8'h23);
        wr(8'h9A, 8'h5B);
        @(negedge mclk);
        twisl_bus_master_i.recvByte(1'b1, v); chk(v, 8'h5B);
        repeat (8) @(posedge mclk);
        rd(8'hE8, v); chk(v & 8'h01, 8'h00);
        twisl_bus_master_i.stop();
        twisl_bus_master_i.start();
        twisl_bus_master_i.sendByte(8'h54, ack); chk(ack, 8'h01);
        waitFlag(); chk(v, 8'h01);
        rd(8'h9A, v); chk(v, 8'h54);
        rd(8'h9A, v); chk(v, 8'h54);
        twisl_bus_master_i.sendByte(8'hC3, ack); chk(ack, 8'h00);
        wr(8'hE8, 8'h04);
        wr(8'hE8, 8'h00);
        @(negedge mclk);
        twisl_bus_master_i.stop();
        twisl_bus_master_i.start();
        twisl_bus_master_i.sendByte(8'h54, ack); chk(ack, 8'h01);
        $display("test transmit and halt done");
        results();
    end
endmodule // twisl_top_tb_top

`default_nettype wire
